// ---- hdl/pbs_pkg.sv ----
package pbs_pkg;
   localparam int unsigned CLK_MHZ = 100;
   // Times in their own units, as printed
   localparam int unsigned T_KEY_LOW_MS = 50;
   localparam int unsigned T_KEY_HIGH_US = 900;
   localparam int unsigned T_KEY_PW_MS = 40;
   localparam int unsigned T_STARTUP_MS = 400;
   localparam int unsigned T_HARD_RESET_S = 14;
   localparam int unsigned T_USB_MS = 100;
   localparam int unsigned T_EN_UP_US = 900;
   localparam int unsigned T_EN_DIS_US = 1;
   localparam int unsigned T_UP_STATE_S = 5;
   localparam int unsigned T_DN_STATE_S = 1;
   localparam int unsigned T_OK_HIGH_US = 1800;
   localparam int unsigned T_OK_LOW_US = 3;
   // Counters run on a 1 us tick; cycles per tick derived from rate
   localparam int unsigned TICK_CYC = CLK_MHZ;
   localparam int unsigned CNT_W = 24;
   localparam int unsigned C_KEY_LOW = T_KEY_LOW_MS * 1000;
   localparam int unsigned C_KEY_HIGH = T_KEY_HIGH_US;
   localparam int unsigned C_KEY_PW = T_KEY_PW_MS * 1000;
   localparam int unsigned C_STARTUP = T_STARTUP_MS * 1000;
   localparam int unsigned C_HARD_RESET = T_HARD_RESET_S * 1000000;
   localparam int unsigned C_USB = T_USB_MS * 1000;
   localparam int unsigned C_EN_UP = T_EN_UP_US;
   localparam int unsigned C_EN_DIS = T_EN_DIS_US;
   localparam int unsigned C_UP_STATE = T_UP_STATE_S * 1000000;
   localparam int unsigned C_DN_STATE = T_DN_STATE_S * 1000000;
   localparam int unsigned C_OK_HIGH = T_OK_HIGH_US;
   localparam int unsigned C_OK_LOW = T_OK_LOW_US;
   typedef enum logic [6:0] {
      state_hard_reset = 7'h01,
      state_off = 7'h02,
      state_startup_a = 7'h04,
      state_startup_b = 7'h08,
      state_running = 7'h10,
      state_shutdown_a = 7'h20,
      state_shutdown_b = 7'h40
   } pbs_state_t;
endpackage

// ---- hdl/pbs_timer.sv ----
`timescale 1ns/1ps
// Counts ticks while run is high; restarts whenever run drops.
module pbs_timer #(
   parameter int unsigned W = 24
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic tick,
   input wire logic run,
   input wire logic [W-1:0] limit,
   output logic done
);
   typedef struct packed {
      logic [W-1:0] cnt;
      logic done;
   } pbs_tmr_t;
   pbs_tmr_t s_ff, nxt_s;
   always_comb begin
      nxt_s = s_ff;
      if (!run) begin
         nxt_s.cnt = '0;
         nxt_s.done = 1'b0;
      end else if (tick && !s_ff.done) begin
         if (s_ff.cnt + 1'b1 >= limit) begin
            nxt_s.done = 1'b1;
         end
         nxt_s.cnt = s_ff.cnt + 1'b1;
      end
   end
   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end
   assign done = s_ff.done;
endmodule

// ---- hdl/pbs_sequencer.sv ----
`timescale 1ns/1ps
module pbs_sequencer
   import pbs_pkg::*;
#(
   parameter int unsigned KEY_LOW_CYC = C_KEY_LOW,
   parameter int unsigned KEY_HIGH_CYC = C_KEY_HIGH,
   parameter int unsigned KEY_PW_CYC = C_KEY_PW,
   parameter int unsigned STARTUP_CYC = C_STARTUP,
   parameter int unsigned HARD_RESET_CYC = C_HARD_RESET,
   parameter int unsigned USB_CYC = C_USB,
   parameter int unsigned EN_UP_CYC = C_EN_UP,
   parameter int unsigned EN_DIS_CYC = C_EN_DIS,
   parameter int unsigned UP_STATE_CYC = C_UP_STATE,
   parameter int unsigned DN_STATE_CYC = C_DN_STATE,
   parameter int unsigned OK_HIGH_CYC = C_OK_HIGH,
   parameter int unsigned OK_LOW_CYC = C_OK_LOW,
   parameter int unsigned TICK_DIV = TICK_CYC
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic key_n_in,
   input wire logic usb_present_in,
   input wire logic buck_en_in,
   input wire logic buck_in_reg_in,
   input wire logic ldo_in_reg_in,
   input wire logic shutdown_req_in,
   output logic key_status_oe,
   output logic key_status_out,
   output logic regs_ok_oe,
   output logic regs_ok_out,
   output logic buck_on_out,
   output logic ldo_on_out,
   output pbs_pkg::pbs_state_t state_out
);
   localparam int unsigned NT = 12;
   localparam int unsigned T_KL = 0;
   localparam int unsigned T_KH = 1;
   localparam int unsigned T_PW = 2;
   localparam int unsigned T_SU = 3;
   localparam int unsigned T_HOLD = 4;
   localparam int unsigned T_USB = 5;
   localparam int unsigned T_EU = 6;
   localparam int unsigned T_ED = 7;
   localparam int unsigned T_UP = 8;
   localparam int unsigned T_DN = 9;
   localparam int unsigned T_OH = 10;
   localparam int unsigned T_OL = 11;

   typedef struct packed {
      logic [1:0] key_sync;
      logic [1:0] usb_sync;
      logic [1:0] en_sync;
      logic [1:0] bok_sync;
      logic [1:0] lok_sync;
      logic [7:0] div;
      logic tick;
      pbs_state_t st;
      logic key_low;
      logic ok_high;
      logic buck_on;
      logic ldo_on;
      logic usb_seen;
      logic en_armed;
      logic ok_pull;
   } pbs_seq_t;

   pbs_seq_t s_ff, nxt_s;
   logic [NT-1:0] run;
   logic [NT-1:0] done;
   logic [CNT_W-1:0] lim [NT];

   function automatic logic in_up(input pbs_state_t st);
      in_up = (st == state_startup_a) || (st == state_startup_b) ||
              (st == state_running);
   endfunction

   function automatic logic in_idle(input pbs_state_t st);
      in_idle = (st == state_hard_reset) || (st == state_off);
   endfunction

   logic key_lo, usb, en, all_ok;
   assign key_lo = !s_ff.key_sync[1];
   assign usb = s_ff.usb_sync[1];
   assign en = s_ff.en_sync[1];
   // Comparators sit in the analog; only enabled regulators count
   assign all_ok = (!s_ff.buck_on || s_ff.bok_sync[1]) &&
                   (!s_ff.ldo_on || s_ff.lok_sync[1]);

   assign lim[T_KL] = CNT_W'(KEY_LOW_CYC);
   assign lim[T_KH] = CNT_W'(KEY_HIGH_CYC);
   assign lim[T_PW] = CNT_W'(KEY_PW_CYC);
   assign lim[T_SU] = CNT_W'(STARTUP_CYC);
   assign lim[T_HOLD] = CNT_W'(HARD_RESET_CYC);
   assign lim[T_USB] = CNT_W'(USB_CYC);
   assign lim[T_EU] = CNT_W'(EN_UP_CYC);
   assign lim[T_ED] = CNT_W'(EN_DIS_CYC);
   assign lim[T_UP] = CNT_W'(UP_STATE_CYC);
   assign lim[T_DN] = CNT_W'(DN_STATE_CYC);
   assign lim[T_OH] = CNT_W'(OK_HIGH_CYC);
   assign lim[T_OL] = CNT_W'(OK_LOW_CYC);

   // Each timer restarts the moment its condition ends
   always_comb begin
      run = '0;
      run[T_KL] = key_lo && in_up(s_ff.st) && !s_ff.key_low;
      run[T_KH] = !key_lo && s_ff.key_low;
      run[T_PW] = s_ff.key_low;
      run[T_SU] = key_lo && in_idle(s_ff.st);
      run[T_HOLD] = key_lo && in_up(s_ff.st);
      run[T_USB] = usb && !s_ff.usb_seen && in_idle(s_ff.st);
      run[T_EU] = en && s_ff.en_armed &&
                  (s_ff.st == state_off);
      run[T_ED] = !en && s_ff.buck_on &&
                  (s_ff.st == state_running);
      run[T_UP] = (s_ff.st == state_startup_a) ||
                  (s_ff.st == state_startup_b);
      run[T_DN] = (s_ff.st == state_shutdown_a) ||
                  (s_ff.st == state_shutdown_b);
      run[T_OH] = all_ok && !s_ff.ok_high;
      run[T_OL] = !all_ok && s_ff.ok_high;
   end

   genvar g;
   generate
      for (g = 0; g < NT; g++) begin : g_tmr
         pbs_timer #(.W(CNT_W)) u_tmr (
            .clk(clk),
            .reset_n(reset_n),
            .tick(s_ff.tick),
            .run(run[g]),
            .limit(lim[g]),
            .done(done[g])
         );
      end
   endgenerate

   always_comb begin
      nxt_s = s_ff;
      // Pins except shutdown_req_in cross from outside, so two flops before use
      nxt_s.key_sync = {s_ff.key_sync[0], key_n_in};
      nxt_s.usb_sync = {s_ff.usb_sync[0], usb_present_in};
      nxt_s.en_sync = {s_ff.en_sync[0], buck_en_in};
      nxt_s.bok_sync = {s_ff.bok_sync[0], buck_in_reg_in};
      nxt_s.lok_sync = {s_ff.lok_sync[0], ldo_in_reg_in};
      nxt_s.tick = 1'b0;
      if (s_ff.div >= 8'(TICK_DIV - 1)) begin
         nxt_s.div = 8'h00;
         nxt_s.tick = 1'b1;
      end else begin
         nxt_s.div = s_ff.div + 8'h01;
      end
      // Status output: debounced key, held low for the min width
      if (done[T_KL]) begin
         nxt_s.key_low = 1'b1;
      end else if (done[T_KH] && done[T_PW]) begin
         nxt_s.key_low = 1'b0;
      end
      if (in_idle(s_ff.st)) begin
         nxt_s.key_low = 1'b0;
      end
      // Re-arm USB start only after power goes away
      if (!usb) begin
         nxt_s.usb_seen = 1'b0;
      end
      // Enable-up needs a low enable seen in off first, so an enable
      // held high through shutdown cannot bounce back to running
      if (s_ff.st != state_off) begin
         nxt_s.en_armed = 1'b0;
      end else if (!en) begin
         nxt_s.en_armed = 1'b1;
      end
      if (done[T_OH]) begin
         nxt_s.ok_high = 1'b1;
      end else if (done[T_OL]) begin
         nxt_s.ok_high = 1'b0;
      end
      case (s_ff.st)
         state_hard_reset, state_off: begin
            nxt_s.buck_on = 1'b0;
            nxt_s.ldo_on = 1'b0;
            if (done[T_SU]) begin
               nxt_s.st = state_startup_a;
            end else if (done[T_USB]) begin
               nxt_s.usb_seen = 1'b1;
               nxt_s.st = state_startup_b;
            end else if (done[T_EU] && s_ff.st == state_off) begin
               nxt_s.st = state_running;
               nxt_s.buck_on = 1'b1;
               nxt_s.ldo_on = 1'b1;
            end
         end
         state_startup_a, state_startup_b: begin
            nxt_s.buck_on = 1'b1;
            nxt_s.ldo_on = 1'b1;
            if (done[T_HOLD]) begin
               nxt_s.st = state_hard_reset;
            end else if (done[T_UP]) begin
               nxt_s.st = state_running;
            end
         end
         state_running: begin
            nxt_s.ldo_on = 1'b1;
            if (en) begin
               nxt_s.buck_on = 1'b1;
            end else if (done[T_ED]) begin
               nxt_s.buck_on = 1'b0;
            end
            if (done[T_HOLD]) begin
               nxt_s.st = state_hard_reset;
            end else if (shutdown_req_in) begin
               nxt_s.st = s_ff.key_low ? state_shutdown_a
                                       : state_shutdown_b;
            end
         end
         state_shutdown_a, state_shutdown_b: begin
            if (done[T_DN]) begin
               nxt_s.st = state_off;
               nxt_s.buck_on = 1'b0;
               nxt_s.ldo_on = 1'b0;
            end
         end
         default: begin
            nxt_s.st = state_hard_reset;
         end
      endcase
      if (s_ff.st == state_hard_reset || nxt_s.st == state_hard_reset) begin
         nxt_s.ok_high = nxt_s.ok_high && !(s_ff.st == state_hard_reset);
      end
      // Pin enable kept as its own flop so the output is registered
      nxt_s.ok_pull = !nxt_s.ok_high;
   end

   always_ff @(posedge clk) begin
      if (!reset_n) begin
         s_ff <= '{key_sync: 2'h3, usb_sync: 2'h0, en_sync: 2'h0,
                   bok_sync: 2'h0, lok_sync: 2'h0, div: 8'h00,
                   tick: 1'b0, st: state_hard_reset, key_low: 1'b0,
                   ok_high: 1'b0, buck_on: 1'b0, ldo_on: 1'b0,
                   usb_seen: 1'b0, en_armed: 1'b0, ok_pull: 1'b1};
      end else begin
         s_ff <= nxt_s;
      end
   end

   // Open drain: output always low, enable high pulls the pin
   assign key_status_out = 1'b0;
   assign key_status_oe = s_ff.key_low;
   assign regs_ok_out = 1'b0;
   assign regs_ok_oe = s_ff.ok_pull;
   assign buck_on_out = s_ff.buck_on;
   assign ldo_on_out = s_ff.ldo_on;
   assign state_out = s_ff.st;
endmodule

// ---- tb/pbs_partner.sv ----
`timescale 1ns/1ps
// Pushbutton with pull-up, host with pull-up on the status line
module pbs_partner (
   input wire logic press,
   input wire logic host_en,
   input wire logic key_status_oe,
   input wire logic key_status_out,
   output logic key_n_in,
   output logic buck_en_in,
   output logic status_level
);
   assign key_n_in = press ? 1'h0 : 1'h1;
   // Host never floats the enable
   assign buck_en_in = host_en;
   assign status_level = key_status_oe ? key_status_out : 1'h1;
endmodule

// ---- tb/pbs_sequencer_asserts.sv ----
`timescale 1ns/1ps
module pbs_sequencer_asserts
   import pbs_pkg::*;
#(
   parameter int unsigned TICK_DIV = 2,
   parameter int unsigned KEY_LOW_CYC = 5,
   parameter int unsigned KEY_HIGH_CYC = 3,
   parameter int unsigned KEY_PW_CYC = 4,
   parameter int unsigned STARTUP_CYC = 10,
   parameter int unsigned HARD_RESET_CYC = 200,
   parameter int unsigned USB_CYC = 8,
   parameter int unsigned OK_HIGH_CYC = 4,
   parameter int unsigned OK_LOW_CYC = 2
) (
   input wire logic clk,
   input wire logic reset_n,
   input wire logic key_n_in,
   input wire logic usb_present_in,
   input wire logic buck_in_reg_in,
   input wire logic ldo_in_reg_in,
   input wire logic key_status_oe,
   input wire logic regs_ok_oe,
   input wire logic buck_on_out,
   input wire logic ldo_on_out,
   input wire pbs_pkg::pbs_state_t state_out
);
   // Run lengths of raw inputs and outputs; design sees inputs later, so minimum bounds are lower and the drop bound higher
   int lo_ff = 0, hi_ff = 0, w_ff = 0, u_ff = 0, g_ff = 0, f_ff = 0;
   logic good;
   assign good = (!buck_on_out || buck_in_reg_in) &&
      (!ldo_on_out || ldo_in_reg_in);
   always_ff @(posedge clk) begin
      lo_ff <= key_n_in ? 0 : lo_ff + 1;
      hi_ff <= key_n_in ? hi_ff + 1 : 0;
      w_ff <= key_status_oe ? w_ff + 1 : 0;
      u_ff <= usb_present_in ? u_ff + 1 : 0;
      g_ff <= good ? g_ff + 1 : 0;
      f_ff <= good ? 0 : f_ff + 1;
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (!reset_n);
   a_status_needs_hold: assert property (
      $rose(key_status_oe) |-> lo_ff >= (KEY_LOW_CYC - 1) * TICK_DIV)
      else $error("status asserted early");
   a_status_release_delay: assert property (
      $fell(key_status_oe) && state_out == state_running |->
      hi_ff >= (KEY_HIGH_CYC - 1) * TICK_DIV) else $error("early release");
   a_status_min_width: assert property (
      $fell(key_status_oe) && state_out == state_running |->
      w_ff >= (KEY_PW_CYC - 1) * TICK_DIV) else $error("status too short");
   a_key_startup_hold: assert property (
      $rose(state_out == state_startup_a) |->
      lo_ff >= (STARTUP_CYC - 1) * TICK_DIV) else $error("early startup");
   a_hard_reset_hold: assert property (
      $rose(state_out == state_hard_reset) |->
      lo_ff >= (HARD_RESET_CYC - 1) * TICK_DIV) else $error("early reset");
   a_usb_startup_hold: assert property (
      $rose(state_out == state_startup_b) |->
      u_ff >= (USB_CYC - 1) * TICK_DIV) else $error("early usb startup");
   a_good_settle: assert property (
      $fell(regs_ok_oe) |-> g_ff >= (OK_HIGH_CYC - 1) * TICK_DIV)
      else $error("power good early");
   a_good_drop_fast: assert property (
      f_ff >= (OK_LOW_CYC + 1) * TICK_DIV + 5 |-> regs_ok_oe)
      else $error("power good late");
   cover property ($rose(key_status_oe));
   cover property ($rose(state_out == state_hard_reset));
   cover property ($rose(regs_ok_oe));
endmodule
bind pbs_sequencer pbs_sequencer_asserts #(.TICK_DIV(TICK_DIV),
   .KEY_LOW_CYC(KEY_LOW_CYC), .KEY_HIGH_CYC(KEY_HIGH_CYC),
   .KEY_PW_CYC(KEY_PW_CYC), .STARTUP_CYC(STARTUP_CYC),
   .HARD_RESET_CYC(HARD_RESET_CYC), .USB_CYC(USB_CYC),
   .OK_HIGH_CYC(OK_HIGH_CYC), .OK_LOW_CYC(OK_LOW_CYC)) u_chk (.*);

// ---- tb/pbs_sequencer_tb.sv ----
`timescale 1ns/1ps
module pbs_sequencer_tb;
   import pbs_pkg::*;
   typedef struct packed {
      logic [4:0] i;
      logic [7:0] n;
      pbs_state_t st;
      logic lv;
   } pbs_row_t;
   // Inputs {press, usb, enable, shutdown, buck fault}; cumulative rows
   pbs_row_t rows [12] = '{
      '{5'h10, 8'h1a, state_startup_a, 1'h1},
      '{5'h00, 8'h3c, state_startup_a, 1'h1},
      '{5'h00, 8'h3c, state_running, 1'h1},
      '{5'h10, 8'h14, state_running, 1'h0},
      '{5'h00, 8'h14, state_running, 1'h1},
      '{5'h02, 8'h04, state_shutdown_b, 1'h1},
      '{5'h00, 8'h38, state_off, 1'h1},
      '{5'h04, 8'h10, state_running, 1'h1},
      '{5'h06, 8'h04, state_shutdown_b, 1'h1},
      '{5'h04, 8'h38, state_off, 1'h1},
      '{5'h08, 8'h1c, state_startup_b, 1'h1},
      '{5'h08, 8'h6e, state_running, 1'h1}};
   logic clk = 1'h0, reset_n = 1'h0, press = 1'h0, usb = 1'h0;
   logic host_en = 1'h0, shut = 1'h0, buck_ok = 1'h1, ldo_ok = 1'h1;
   logic key_n, buck_en, oe, od, ok_oe, buck_on, level, ok_od, ldo_on;
   pbs_state_t st;
   int n_fail = 0, tests_run = 0;
   always #5 clk = ~clk;
   pbs_partner u_partner (.press(press), .host_en(host_en),
      .key_status_oe(oe), .key_status_out(od), .key_n_in(key_n),
      .buck_en_in(buck_en), .status_level(level));
   // Counts shortened to ticks of two cycles
   localparam int unsigned P_HOLD = 200, P_UP = 50, P_DN = 20, P_SU = 10;
   localparam int unsigned P_KL = 5, P_PW = 4, P_KH = 3, P_USB = 8;
   localparam int unsigned P_EU = 3, P_ED = 1, P_OH = 4, P_OL = 2;
   localparam int unsigned P_DIV = 2;
   pbs_sequencer #(.HARD_RESET_CYC(P_HOLD), .UP_STATE_CYC(P_UP),
      .DN_STATE_CYC(P_DN), .STARTUP_CYC(P_SU), .KEY_LOW_CYC(P_KL),
      .KEY_PW_CYC(P_PW), .KEY_HIGH_CYC(P_KH), .USB_CYC(P_USB),
      .EN_UP_CYC(P_EU), .EN_DIS_CYC(P_ED), .OK_HIGH_CYC(P_OH),
      .OK_LOW_CYC(P_OL), .TICK_DIV(P_DIV))
      u_dut (.clk(clk), .reset_n(reset_n), .key_n_in(key_n),
      .usb_present_in(usb), .buck_en_in(buck_en), .buck_in_reg_in(buck_ok),
      .ldo_in_reg_in(ldo_ok), .shutdown_req_in(shut), .key_status_oe(oe),
      .key_status_out(od), .regs_ok_oe(ok_oe), .regs_ok_out(ok_od),
      .buck_on_out(buck_on), .ldo_on_out(ldo_on), .state_out(st));
   task automatic chk(input string nm, input logic [6:0] s,
      input logic [6:0] e);
      tests_run++;
      if (s !== e) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, s);
      end
   endtask
   task automatic go(input logic [4:0] i, input logic [7:0] n);
      @(posedge clk);
      {press, usb, host_en, shut, buck_ok} <= i ^ 5'h01;
      repeat (n) @(posedge clk);
      #1;
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", tests_run, n_fail);
      if (n_fail == 0 && tests_run > 0)
         $display("ALL TESTS PASSED");
      else
         $display("TESTS FAILED");
      $finish;
   endtask
   initial begin
      #100000;
      n_fail++;
      report_and_stop;
   end
   initial begin
      repeat (5) @(posedge clk);
      reset_n <= 1'h1;
      #1;
      chk("reset state", st, state_hard_reset);
      chk("reset status", oe, 1'h0);
      chk("reset power good", ok_oe, 1'h1);
      chk("reset ldo", ldo_on, 1'h0);
      chk("power good data", ok_od, 1'h0);
      foreach (rows[k]) begin
         go(rows[k].i, rows[k].n);
         chk("state", st, rows[k].st);
         chk("status", level, rows[k].lv);
         chk("ldo", ldo_on, rows[k].st != state_off);
      end
      go(5'h0c, 8'h0a);
      chk("buck on", buck_on, 1'h1);
      go(5'h0c, 8'h14);
      chk("power good", ok_oe, 1'h0);
      go(5'h0d, 8'h0c);
      chk("fault drop", ok_oe, 1'h1);
      go(5'h0c, 8'h04);
      chk("settle hold", ok_oe, 1'h1);
      go(5'h0c, 8'h14);
      chk("power good again", ok_oe, 1'h0);
      @(posedge clk);
      ldo_ok <= 1'h0;
      go(5'h0c, 8'h0c);
      chk("ldo fault drop", ok_oe, 1'h1);
      @(posedge clk);
      ldo_ok <= 1'h1;
      go(5'h0c, 8'h14);
      chk("ldo good again", ok_oe, 1'h0);
      go(5'h08, 8'h0a);
      chk("buck off", buck_on, 1'h0);
      go(5'h18, 8'h06);
      go(5'h08, 8'h14);
      chk("short press", level, 1'h1);
      go(5'h18, 8'hbe);
      go(5'h18, 8'hbe);
      chk("long press", st, state_running);
      chk("long press status", level, 1'h0);
      go(5'h18, 8'h28);
      chk("hard reset", st, state_hard_reset);
      chk("hard reset ldo", ldo_on, 1'h0);
      go(5'h00, 8'h04);
      // Reset again in mid-run, from a startup state
      @(posedge clk);
      reset_n <= 1'h0;
      repeat (3) @(posedge clk);
      reset_n <= 1'h1;
      #1;
      chk("mid reset state", st, state_hard_reset);
      chk("mid reset status", oe, 1'h0);
      chk("mid reset power good", ok_oe, 1'h1);
      chk("mid reset buck", buck_on, 1'h0);
      chk("mid reset ldo", ldo_on, 1'h0);
      report_and_stop;
   end
endmodule
